/* File: logic/casd_datapath.sv */
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`default_nettype none
module casd_datapath (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_alu_valid,
    input wire casd_pkg::casd_alu_req_t i_alu_req,
    output casd_pkg::casd_alu_res_t o_alu_res,
    output logic o_alu_res_valid,
    input wire logic i_div_start,
    input wire casd_pkg::casd_div_req_t i_div_req,
    input wire logic i_div_hold,
    output logic o_div_busy,
    output logic [3:0] o_div_raddr_lo,
    output logic [3:0] o_div_raddr_hi,
    output logic [3:0] o_div_raddr_dvr,
    input wire logic [15:0] i_div_rdata_lo,
    input wire logic [15:0] i_div_rdata_hi,
    input wire logic [15:0] i_div_rdata_dvr,
    output logic o_div_wb_valid,
    output logic [15:0] o_working_reg_zero_data,
    output logic [15:0] o_working_reg_one_data,
    input wire logic i_repeat_active,
    input wire logic i_nesting_disable,
    input wire logic i_ipl_load,
    input wire logic [3:0] i_ipl_value,
    output logic [3:0] o_cpu_priority,
    output logic o_user_irq_off,
    output logic [15:0] o_alu_status_flags
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte enables of the low half-word as a bit mask
    function automatic logic [15:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    // Two's complement magnitude, only when the value is signed
    function automatic logic [31:0] casd_mag(input logic [31:0] v, input logic sgn);
        casd_mag = (sgn && v[31]) ? (~v + 32'h00000001) : v;
    endfunction

    // Which status flags an operation writes
    function automatic logic [15:0] casd_affect(input casd_pkg::casd_op_t op);
        case (op)
            casd_pkg::OP_ADD, casd_pkg::OP_ADDC, casd_pkg::OP_SUB, casd_pkg::OP_SUBB: begin
                casd_affect = casd_pkg::SR_DC_M | casd_pkg::SR_N_M | casd_pkg::SR_OV_M |
                              casd_pkg::SR_Z_M | casd_pkg::SR_C_M;
            end
            casd_pkg::OP_AND, casd_pkg::OP_IOR, casd_pkg::OP_XOR, casd_pkg::OP_ASR,
            casd_pkg::OP_SL, casd_pkg::OP_LSR: begin
                casd_affect = casd_pkg::SR_N_M | casd_pkg::SR_Z_M;
            end
            default: begin
                casd_affect = 16'h0000;
            end
        endcase
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] sr_r;
    logic [15:0] sr_nxt;
    logic priority_high_bit_r;
    logic priority_high_bit_nxt;
    logic ack_r;
    logic [31:0] rdata_r;

    // ------------------------------------------------------------
    // Bus slave: one wait state for every access
    // ------------------------------------------------------------
    wire req = i_avs_read | i_avs_write;
    wire wr_fire = i_avs_write & ack_r;
    wire [15:0] wd16 = i_avs_writedata[15:0];
    wire [15:0] lanes = lane_mask(i_avs_byteenable);
    wire sr_sel = i_avs_address == casd_pkg::ADDR_STATUS;
    wire cc_sel = i_avs_address == casd_pkg::ADDR_CONTROL;
    wire [15:0] cc_rd = ({16{priority_high_bit_r}} & (16'h0001 << casd_pkg::CC_PRIORITY_HIGH_BIT)) |
                        casd_pkg::CC_RSVD_M;
    // Unmapped addresses read zero and swallow writes
    wire [31:0] rd_mux = sr_sel ? {16'h0000, sr_r} :
                         cc_sel ? {16'h0000, cc_rd} : 32'h00000000;

    assign o_avs_waitrequest = req & ~ack_r;
    assign o_avs_readdata = rdata_r;

    // Ack toggles so every request sees exactly one wait cycle
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            ack_r <= req & ~ack_r;
            if (i_avs_read && !ack_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Adder and flag generation
    // ------------------------------------------------------------
    wire [15:0] a = i_alu_req.a;
    wire [15:0] b = i_alu_req.b;
    wire bm = i_alu_req.byte_mode;
    wire alu_fire = i_alu_valid;
    wire is_sub = (i_alu_req.op == casd_pkg::OP_SUB) | (i_alu_req.op == casd_pkg::OP_SUBB);
    wire use_c = (i_alu_req.op == casd_pkg::OP_ADDC) | (i_alu_req.op == casd_pkg::OP_SUBB);
    // Subtract adds the inverse so carry out is the inverted borrow
    wire [15:0] b_eff = is_sub ? ~b : b;
    wire cin = use_c ? sr_r[casd_pkg::SR_C] : is_sub;
    wire [16:0] sum_w = {1'b0, a} + {1'b0, b_eff} + 17'(cin);
    wire [8:0] sum_b = {1'b0, a[7:0]} + {1'b0, b_eff[7:0]} + 9'(cin);
    wire [4:0] sum_n = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + 5'(cin);
    wire c_new = bm ? sum_b[8] : sum_w[16];
    wire dc_new = bm ? sum_n[4] : sum_b[8];

    // ------------------------------------------------------------
    // Barrel shifter, one cycle for any amount 0..15
    // ------------------------------------------------------------
    wire [15:0] sh_sx = bm ? {{8{a[7]}}, a[7:0]} : a;
    wire [15:0] sh_zx = bm ? {8'h00, a[7:0]} : a;
    wire [15:0] asr_v = 16'($signed(sh_sx) >>> i_alu_req.shamt);
    wire [15:0] lsr_v = sh_zx >> i_alu_req.shamt;
    wire [15:0] sl_v = a << i_alu_req.shamt;

    // Result select for the operation in flight
    logic [15:0] r;
    always_comb begin
        case (i_alu_req.op)
            casd_pkg::OP_ADD, casd_pkg::OP_ADDC, casd_pkg::OP_SUB, casd_pkg::OP_SUBB: begin
                r = sum_w[15:0];
            end
            casd_pkg::OP_AND: begin
                r = a & b;
            end
            casd_pkg::OP_IOR: begin
                r = a | b;
            end
            casd_pkg::OP_XOR: begin
                r = a ^ b;
            end
            casd_pkg::OP_ASR: begin
                r = asr_v;
            end
            casd_pkg::OP_LSR: begin
                r = lsr_v;
            end
            casd_pkg::OP_SL: begin
                r = sl_v;
            end
            default: begin
                r = a;
            end
        endcase
    end

    // Flags judged at the selected width
    wire msb_r = bm ? r[7] : r[15];
    wire msb_a = bm ? a[7] : a[15];
    wire msb_b = bm ? b_eff[7] : b_eff[15];
    wire is_zero = bm ? (r[7:0] == 8'h00) : (r == 16'h0000);
    wire n_new = msb_r;
    wire ov_new = (msb_a == msb_b) & (msb_r != msb_a);
    // Carry-chained ops can only clear zero, so multi-word results test whole
    wire z_new = use_c ? (sr_r[casd_pkg::SR_Z] & is_zero) : is_zero;
    // Byte results leave the upper byte of the destination untouched
    wire [15:0] res_out = bm ? {a[15:8], r[7:0]} : r;

    // ------------------------------------------------------------
    // Multiplier: 17x17 signed core, sign bits chosen per mode
    // ------------------------------------------------------------
    wire mm_ss = i_alu_req.mul_mode == casd_pkg::MUL_SS;
    wire mm_su = i_alu_req.mul_mode == casd_pkg::MUL_SU;
    wire mm_us = i_alu_req.mul_mode == casd_pkg::MUL_US;
    wire mm_sl = i_alu_req.mul_mode == casd_pkg::MUL_SL5;
    wire mm_l5 = mm_sl | (i_alu_req.mul_mode == casd_pkg::MUL_UL5);
    wire mm_b8 = i_alu_req.mul_mode == casd_pkg::MUL_UU8;
    wire sa = (mm_ss | mm_su | mm_sl) & a[15];
    wire sb = (mm_ss | mm_us) & b[15];
    wire [16:0] ma = mm_b8 ? {9'h000, a[7:0]} : {sa, a};
    wire [16:0] mb = mm_b8 ? {9'h000, b[7:0]} :
                     mm_l5 ? {12'h000, b[4:0]} : {sb, b};
    wire signed [33:0] prod = $signed(ma) * $signed(mb);
    wire is_mul = i_alu_req.op == casd_pkg::OP_MUL;

    // Results registered; multiply writes no flags
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_alu_res <= '0;
            o_alu_res_valid <= 1'b0;
        end else begin
            o_alu_res_valid <= alu_fire;
            if (alu_fire) begin
                o_alu_res.result <= res_out;
                o_alu_res.product <= is_mul ? prod[31:0] : o_alu_res.product;
            end
        end
    end

    // ------------------------------------------------------------
    // Status register next value
    // ------------------------------------------------------------
    // Priority field is frozen against software while nesting is off
    wire [15:0] ipl_lock = i_nesting_disable ? ~casd_pkg::SR_IPL_M : 16'hffff;
    wire [15:0] sw_m = lanes & casd_pkg::SR_SW_M & ipl_lock &
                       {16{wr_fire & sr_sel}};
    wire [15:0] sr_sw = (sr_r & ~sw_m) | (wd16 & sw_m);
    wire [15:0] hw_m = casd_affect(i_alu_req.op) & {16{alu_fire}};
    wire [15:0] hw_v = ({16{dc_new}} & casd_pkg::SR_DC_M) |
                       ({16{n_new}} & casd_pkg::SR_N_M) |
                       ({16{ov_new}} & casd_pkg::SR_OV_M) |
                       ({16{z_new}} & casd_pkg::SR_Z_M) |
                       ({16{c_new}} & casd_pkg::SR_C_M);
    wire [15:0] sr_alu = (sr_sw & ~hw_m) | (hw_v & hw_m); // Hardware beats software
    wire [15:0] ipl_v = 16'(i_ipl_value[2:0]) << casd_pkg::SR_IPL_LSB;
    wire [15:0] ipl_m = casd_pkg::SR_IPL_M & {16{i_ipl_load}};
    wire [15:0] sr_ipl = (sr_alu & ~ipl_m) | (ipl_v & ipl_m);
    wire [15:0] ra_v = {16{i_repeat_active}} & casd_pkg::SR_RA_M;
    assign sr_nxt = ((sr_ipl & ~casd_pkg::SR_RA_M) | ra_v) & casd_pkg::SR_IMPL_M;

    // Control priority bit: software may clear, hardware load wins
    wire cc_clr = wr_fire & cc_sel & i_avs_byteenable[0] &
                  ~i_avs_writedata[casd_pkg::CC_PRIORITY_HIGH_BIT];
    assign priority_high_bit_nxt = i_ipl_load ? i_ipl_value[3] : (priority_high_bit_r & ~cc_clr);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sr_r <= casd_pkg::SR_RESET;
            priority_high_bit_r <= casd_pkg::CC_PRIORITY_HIGH_BIT_RESET;
        end else begin
            sr_r <= sr_nxt;
            priority_high_bit_r <= priority_high_bit_nxt;
        end
    end

    wire [2:0] ipl_lo = sr_r[casd_pkg::SR_IPL_LSB +: 3];
    assign o_cpu_priority = {priority_high_bit_r, ipl_lo};
    assign o_user_irq_off = ipl_lo == casd_pkg::IPL_USER_OFF;
    assign o_alu_status_flags = sr_r;

    // ------------------------------------------------------------
    // Divider sequencer
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        DV_IDLE = 5'b00001,
        DV_LOAD = 5'b00010,
        DV_ITER = 5'b00100,
        DV_FIX = 5'b01000,
        DV_DONE = 5'b10000
    } casd_dv_state_t;

    casd_dv_state_t dv_r;
    casd_dv_state_t dv_nxt;
    casd_pkg::casd_div_req_t dreq_r;
    logic [3:0] cnt_r;
    logic [15:0] quo_r;
    logic [15:0] rem_r;
    logic [15:0] dvr_r;
    logic neg_q_r;
    logic neg_r_r;

    // Dividend: full pair, or one word extended to 32 bits
    wire sgn = dreq_r.is_signed;
    wire [31:0] dvd32 = dreq_r.wide ? {i_div_rdata_hi, i_div_rdata_lo} :
                        sgn ? {{16{i_div_rdata_lo[15]}}, i_div_rdata_lo} :
                        {16'h0000, i_div_rdata_lo};
    wire [31:0] dvr32 = sgn ? {{16{i_div_rdata_dvr[15]}}, i_div_rdata_dvr} :
                        {16'h0000, i_div_rdata_dvr};
    wire [31:0] dvd_mag = casd_mag(dvd32, sgn);
    wire [31:0] dvr_mag = casd_mag(dvr32, sgn);
    // One shift-subtract step; quotient width fixes the step count
    wire [16:0] sh = {rem_r, quo_r[15]};
    wire [16:0] trial = sh - {1'b0, dvr_r};
    wire take = ~trial[16];
    wire last = cnt_r == casd_pkg::DIV_LAST;

    // Hold freezes the sequence so an interrupt can slot in
    always_comb begin
        dv_nxt = dv_r;
        case (dv_r)
            DV_IDLE: begin
                if (i_div_start) begin
                    dv_nxt = DV_LOAD;
                end
            end
            DV_LOAD: begin
                dv_nxt = i_div_hold ? DV_LOAD : DV_ITER;
            end
            DV_ITER: begin
                dv_nxt = (last && !i_div_hold) ? DV_FIX : DV_ITER;
            end
            DV_FIX: begin
                dv_nxt = i_div_hold ? DV_FIX : DV_DONE;
            end
            DV_DONE: begin
                dv_nxt = DV_IDLE;
            end
            default: begin
                dv_nxt = DV_IDLE;
            end
        endcase
    end

    // Datapath of the divider, 1 + 16 + 1 + 1 cycles when not held
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dv_r <= DV_IDLE;
            dreq_r <= '0;
            cnt_r <= 4'h0;
            quo_r <= 16'h0000;
            rem_r <= 16'h0000;
            dvr_r <= 16'h0000;
            neg_q_r <= 1'b0;
            neg_r_r <= 1'b0;
            o_working_reg_zero_data <= 16'h0000;
            o_working_reg_one_data <= 16'h0000;
        end else begin
            dv_r <= dv_nxt;
            if (dv_r == DV_IDLE && i_div_start) begin
                dreq_r <= i_div_req;
                cnt_r <= 4'h0;
            end
            if (dv_r == DV_LOAD && !i_div_hold) begin
                rem_r <= dvd_mag[31:16];
                quo_r <= dvd_mag[15:0];
                dvr_r <= dvr_mag[15:0];
                neg_q_r <= sgn & (dvd32[31] ^ dvr32[31]);
                neg_r_r <= sgn & dvd32[31];
            end
            if (dv_r == DV_ITER && !i_div_hold) begin
                rem_r <= take ? trial[15:0] : sh[15:0];
                quo_r <= {quo_r[14:0], take};
                cnt_r <= cnt_r + 4'h1;
            end
            if (dv_r == DV_FIX && !i_div_hold) begin
                o_working_reg_zero_data <= neg_q_r ? (~quo_r + 16'h0001) : quo_r;
                o_working_reg_one_data <= neg_r_r ? (~rem_r + 16'h0001) : rem_r;
            end
        end
    end

    // Operand fetch addresses: any divisor, even-aligned dividend pair
    assign o_div_raddr_lo = {dreq_r.pair_sel, 1'b0};
    assign o_div_raddr_hi = {dreq_r.pair_sel, 1'b1};
    assign o_div_raddr_dvr = dreq_r.divisor_sel;
    assign o_div_busy = dv_r != DV_IDLE;
    assign o_div_wb_valid = dv_r == DV_DONE;
endmodule
`default_nettype wire

/* File: logic/casd_pkg.sv */
`default_nettype none
package casd_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses on the slave port)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CONTROL = 4'h4;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int unsigned SR_C = 0;
    localparam int unsigned SR_Z = 1;
    localparam int unsigned SR_N = 3;
    localparam int unsigned SR_IPL_LSB = 5;
    localparam logic [15:0] SR_C_M = 16'h0001;
    localparam logic [15:0] SR_Z_M = 16'h0002;
    localparam logic [15:0] SR_OV_M = 16'h0004;
    localparam logic [15:0] SR_N_M = 16'h0008;
    localparam logic [15:0] SR_RA_M = 16'h0010;
    localparam logic [15:0] SR_IPL_M = 16'h00e0;
    localparam logic [15:0] SR_DC_M = 16'h0100;
    localparam logic [15:0] SR_IMPL_M = 16'h01ff;
    localparam logic [15:0] SR_SW_M = 16'h01ef;
    localparam logic [15:0] SR_RESET = 16'h0000;
    localparam logic [2:0] IPL_USER_OFF = 3'h7;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int unsigned CC_PRIORITY_HIGH_BIT = 3;
    localparam logic [15:0] CC_RSVD_M = 16'h0004;
    localparam logic CC_PRIORITY_HIGH_BIT_RESET = 1'b0;

    // ------------------------------------------------------------
    // Divider timing: load, one step per divisor bit, fix, write
    // ------------------------------------------------------------
    localparam int unsigned DIV_ITERS = 16;
    localparam int unsigned DIV_CYCLES = 19;
    localparam logic [3:0] DIV_LAST = 4'(DIV_ITERS - 1);

    typedef enum logic [3:0] {
        OP_NOP, OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR,
        OP_XOR, OP_ASR, OP_SL, OP_LSR, OP_MUL
    } casd_op_t;

    typedef enum logic [2:0] {
        MUL_SS, MUL_UU, MUL_SU, MUL_US, MUL_SL5, MUL_UL5, MUL_UU8
    } casd_mul_t;

    typedef struct packed {
        casd_op_t op;
        logic byte_mode;
        casd_mul_t mul_mode;
        logic [15:0] a;
        logic [15:0] b;
        logic [3:0] shamt;
    } casd_alu_req_t;

    typedef struct packed {
        logic is_signed;
        logic wide;
        logic [3:0] divisor_sel;
        logic [2:0] pair_sel;
    } casd_div_req_t;

    typedef struct packed {
        logic [15:0] result;
        logic [31:0] product;
    } casd_alu_res_t;
endpackage
`default_nettype wire

/* File: tb/casd_assertions.sv */
`default_nettype none
module casd_chk (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic i_alu_valid,
    input wire casd_pkg::casd_alu_req_t i_alu_req,
    input wire logic o_alu_res_valid,
    input wire logic i_div_start,
    input wire logic i_div_hold,
    input wire logic o_div_busy,
    input wire logic o_div_wb_valid,
    input wire logic i_repeat_active,
    input wire logic i_nesting_disable,
    input wire logic i_ipl_load,
    input wire logic [3:0] i_ipl_value,
    input wire logic [3:0] o_cpu_priority,
    input wire logic o_user_irq_off,
    input wire logic [15:0] o_alu_status_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic [7:0] cnt_r;
    // --------------------------------------------------------------
    // Divide age counter
    // --------------------------------------------------------------
    // Held cycles are not counted, so a pause stretches the wait only
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_r <= 8'h00;
        end else if (i_div_start && !o_div_busy) begin
            cnt_r <= 8'h01;
        end else if (!i_div_hold) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    upper_zero_a: assert property (o_avs_readdata[31:16] == 16'h0000)
        else $error("readdata upper half not zero");
    status_unimpl_a: assert property (o_alu_status_flags[15:9] == 7'h00)
        else $error("status unimplemented bits set");
    repeat_copy_a: assert property (o_alu_status_flags[4] == $past(i_repeat_active))
        else $error("repeat flag does not follow loop");
    user_off_a: assert property (o_user_irq_off == (o_alu_status_flags[7:5] == 3'h7))
        else $error("user interrupt off wrong");
    prio_concat_a: assert property (o_cpu_priority[2:0] == o_alu_status_flags[7:5])
        else $error("priority low field mismatch");
    prio_load_a: assert property (i_ipl_load |=> o_cpu_priority == $past(i_ipl_value))
        else $error("priority load lost");
    nest_lock_a: assert property (i_nesting_disable && !i_ipl_load
        |=> $stable(o_alu_status_flags[7:5])) else $error("locked priority changed");
    mul_keep_a: assert property (i_alu_valid && i_alu_req.op == casd_pkg::OP_MUL
        && !i_avs_write && !i_ipl_load
        |=> ((o_alu_status_flags ^ $past(o_alu_status_flags)) & 16'hffef) == 16'h0000)
        else $error("multiply changed flags");
    res_pulse_a: assert property (i_alu_valid |=> o_alu_res_valid ##1
        (!o_alu_res_valid || $past(i_alu_valid))) else $error("result valid not one cycle later");
    div_time_a: assert property (o_div_wb_valid |-> cnt_r == 8'd19)
        else $error("divide not 19 active cycles");
endmodule
bind casd_datapath casd_chk u_chk (.i_clk, .i_rst_b, .i_avs_write, .o_avs_readdata,
    .i_alu_valid, .i_alu_req, .o_alu_res_valid, .i_div_start, .i_div_hold, .o_div_busy,
    .o_div_wb_valid, .i_repeat_active, .i_nesting_disable, .i_ipl_load, .i_ipl_value,
    .o_cpu_priority, .o_user_irq_off, .o_alu_status_flags);
`default_nettype wire

/* File: tb/casd_wreg_model.sv */
`default_nettype none
module casd_wreg_model (
    input wire logic i_clk,
    input wire logic [3:0] i_addr_lo,
    input wire logic [3:0] i_addr_hi,
    input wire logic [3:0] i_addr_dvr,
    input wire logic i_wb_valid,
    input wire logic [15:0] i_quot,
    input wire logic [15:0] i_rem,
    output logic [15:0] o_rdata_lo,
    output logic [15:0] o_rdata_hi,
    output logic [15:0] o_rdata_dvr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] wreg [16];
    // Any register may be read as divisor or dividend half
    assign o_rdata_lo = wreg[i_addr_lo];
    assign o_rdata_hi = wreg[i_addr_hi];
    assign o_rdata_dvr = wreg[i_addr_dvr];
    // Quotient and remainder land in the two lowest registers
    always @(posedge i_clk) begin
        if (i_wb_valid) begin
            wreg[0] <= i_quot;
            wreg[1] <= i_rem;
        end
    end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_rst_b = 0, i_avs_read = 0, i_avs_write = 0, i_alu_valid = 0;
    logic i_div_start = 0, i_div_hold = 0, i_repeat_active = 0, i_nesting_disable = 0;
    logic i_ipl_load = 0, o_avs_waitrequest, o_alu_res_valid, o_div_busy, o_div_wb_valid;
    logic o_user_irq_off;
    logic [3:0] i_avs_address = 0, i_ipl_value = 0, o_cpu_priority;
    logic [3:0] o_div_raddr_lo, o_div_raddr_hi, o_div_raddr_dvr;
    logic [31:0] i_avs_writedata = 0, o_avs_readdata, rd;
    logic [15:0] i_div_rdata_lo, i_div_rdata_hi, i_div_rdata_dvr, o_alu_status_flags;
    logic [15:0] o_working_reg_zero_data, o_working_reg_one_data;
    casd_pkg::casd_alu_req_t i_alu_req = '0;
    casd_pkg::casd_alu_res_t o_alu_res;
    casd_pkg::casd_div_req_t i_div_req = '0;
    int err_total = 0, compares = 0, cyc = 0;
    logic [31:0] prod [7] = '{32'h1, 32'hfffe0001, 32'hffff0001, 32'hffff0001, 32'hffffffe1,
        32'h001effe1, 32'h0000fe01};
    casd_datapath u_dut (.i_clk, .i_rst_b, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .i_avs_byteenable(4'h3), .o_avs_readdata, .o_avs_waitrequest,
        .i_alu_valid, .i_alu_req, .o_alu_res, .o_alu_res_valid, .i_div_start, .i_div_req,
        .i_div_hold, .o_div_busy, .o_div_raddr_lo, .o_div_raddr_hi, .o_div_raddr_dvr,
        .i_div_rdata_lo, .i_div_rdata_hi, .i_div_rdata_dvr, .o_div_wb_valid,
        .o_working_reg_zero_data, .o_working_reg_one_data, .i_repeat_active,
        .i_nesting_disable, .i_ipl_load, .i_ipl_value, .o_cpu_priority, .o_user_irq_off,
        .o_alu_status_flags);
    casd_wreg_model u_wreg (.i_clk, .i_addr_lo(o_div_raddr_lo), .i_addr_hi(o_div_raddr_hi),
        .i_addr_dvr(o_div_raddr_dvr), .i_wb_valid(o_div_wb_valid),
        .i_quot(o_working_reg_zero_data), .i_rem(o_working_reg_one_data),
        .o_rdata_lo(i_div_rdata_lo), .o_rdata_hi(i_div_rdata_hi),
        .o_rdata_dvr(i_div_rdata_dvr));
    // --------------------------------------------------------------
    // Clock, hang guard and helpers
    // --------------------------------------------------------------
    always #20 i_clk = ~i_clk;
    // A whole run needs well under a thousand cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Waitrequest and read data are the values sampled at the edge
    task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
        @(posedge i_clk);
        {i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} <= {!wr, wr, ad, wd};
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        {i_avs_read, i_avs_write} <= 2'b00;
    endtask
    task automatic alu(input casd_pkg::casd_op_t op, input logic bm, input logic [2:0] mm,
        input logic [15:0] a, input logic [15:0] b, input logic [3:0] sh,
        input logic [15:0] er, input logic [15:0] ef);
        @(posedge i_clk);
        i_alu_valid <= 1'b1;
        i_alu_req <= '{op, bm, casd_pkg::casd_mul_t'(mm), a, b, sh};
        @(posedge i_clk);
        i_alu_valid <= 1'b0;
        @(negedge i_clk);
        if (op != casd_pkg::OP_MUL) chk("alu result", er, o_alu_res.result);
        chk("status flags", ef, o_alu_status_flags);
    endtask
    // A refused restart and an optional pause ride along with every divide
    task automatic dv(input logic sg, input logic wd, input logic [2:0] p,
        input logic [15:0] q, input logic [15:0] r, input logic hold);
        @(posedge i_clk);
        i_div_start <= 1'b1;
        i_div_req <= '{sg, wd, 4'h9, p};
        @(posedge i_clk);
        i_div_req.divisor_sel <= 4'h2;
        i_div_hold <= hold;
        repeat (3) @(posedge i_clk);
        {i_div_start, i_div_hold} <= 2'b00;
        do @(negedge i_clk); while (o_div_wb_valid !== 1'b1);
        @(negedge i_clk);
        chk("quotient", q, u_wreg.wreg[0]);
        chk("remainder", r, u_wreg.wreg[1]);
    endtask
    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    initial begin
        for (int i = 0; i < 16; i++) u_wreg.wreg[i] = 16'h0000;
        {u_wreg.wreg[2], u_wreg.wreg[4], u_wreg.wreg[5]} = {16'h0064, 16'hff9c, 16'hffff};
        u_wreg.wreg[9] = 16'h0007;
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1'b1;
        bus(0, casd_pkg::ADDR_STATUS, 0); chk("status", 32'h0, rd);
        bus(0, casd_pkg::ADDR_CONTROL, 0); chk("control", 32'h4, rd);
        bus(1, 4'h8, 32'hffff); bus(0, 4'h8, 0); chk("unmapped", 32'h0, rd);
        {i_ipl_load, i_ipl_value} <= 5'h1b;
        @(posedge i_clk);
        i_ipl_load <= 1'b0;
        bus(0, casd_pkg::ADDR_CONTROL, 0); chk("control", 32'hc, rd);
        chk("priority", 32'hb, 32'(o_cpu_priority));
        bus(1, casd_pkg::ADDR_CONTROL, 32'hffff); bus(0, casd_pkg::ADDR_CONTROL, 0);
        chk("control", 32'hc, rd);
        bus(1, casd_pkg::ADDR_CONTROL, 0); bus(0, casd_pkg::ADDR_CONTROL, 0);
        chk("control", 32'h4, rd);
        i_nesting_disable <= 1'b1;
        bus(1, casd_pkg::ADDR_STATUS, 32'hffff); bus(0, casd_pkg::ADDR_STATUS, 0);
        chk("status", 32'h16f, rd);
        i_nesting_disable <= 1'b0;
        bus(1, casd_pkg::ADDR_STATUS, 32'hffff);
        @(posedge i_clk);
        chk("irq off", 1, 32'(o_user_irq_off));
        i_repeat_active <= 1'b1;
        bus(0, casd_pkg::ADDR_STATUS, 0); chk("status", 32'h1ff, rd);
        i_repeat_active <= 1'b0;
        bus(1, casd_pkg::ADDR_STATUS, 0);
        alu(casd_pkg::OP_ADD, 0, 0, 16'h7fff, 16'h1, 0, 16'h8000, 16'h010c);
        alu(casd_pkg::OP_ADD, 1, 0, 16'h00ff, 16'h1, 0, 16'h0000, 16'h0103);
        alu(casd_pkg::OP_SUB, 0, 0, 16'h0000, 16'h1, 0, 16'hffff, 16'h0008);
        alu(casd_pkg::OP_SUB, 0, 0, 16'h0005, 16'h5, 0, 16'h0000, 16'h0103);
        alu(casd_pkg::OP_SL, 0, 0, 16'h0001, 16'h0, 15, 16'h8000, 16'h0109);
        alu(casd_pkg::OP_ASR, 0, 0, 16'h8000, 16'h0, 15, 16'hffff, 16'h0109);
        alu(casd_pkg::OP_LSR, 0, 0, 16'h8000, 16'h0, 15, 16'h0001, 16'h0101);
        alu(casd_pkg::OP_ADDC, 0, 0, 16'hffff, 16'h0, 0, 16'h0000, 16'h0101);
        alu(casd_pkg::OP_XOR, 0, 0, 16'h00f0, 16'h00f0, 0, 16'h0000, 16'h0103);
        for (int i = 0; i < 7; i++) begin
            alu(casd_pkg::OP_MUL, 0, 3'(i), 16'hffff, 16'hffff, 0, 0, 16'h0103);
            chk("product", prod[i], o_alu_res.product);
        end
        dv(0, 0, 3'h1, 16'h000e, 16'h0002, 1);
        dv(0, 1, 3'h1, 16'h000e, 16'h0002, 0);
        dv(1, 0, 3'h2, 16'hfff2, 16'hfffe, 0);
        dv(1, 1, 3'h2, 16'hfff2, 16'hfffe, 1);
        complete_run();
    end
endmodule
`default_nettype wire
